// File: inc/float_regs.svh
`ifndef FLOAT_REGS_SVH
`define FLOAT_REGS_SVH
// Behaviour
// - Status bits 7:4 hold slot B flags, channels 1 to 4, set at target count.
// - Status bits 3:0 hold slot A flags, channels 1 to 4, set at target count.
// - Reading status returns both slots' flags then clears them; bits 15:8 read zero.
// - Slot A count select: 0 never, 1/2/3 flag after 1/4/16 exceedances.
// - Slot B count select works the same: 0 never, 1/2/3 need 1/4/16.
// - Slot A subtract samples above the 14-bit slot A limit bump its counter.
// - Slot B subtract samples above the 14-bit slot B limit bump its counter.
// - Slot A emitter choice: 0 none, 1 to 3 pick LED one to three.
// - Slot B emitter choice: 0 none, 1 to 3 pick LED one to three.
// - Slot A pulse width is five bits in 1 us steps, reset 0x03.
// - Slot B pulse width is five bits in 1 us steps, reset 0x03.
// - Slot A eight-bit delay to first pulse, reset 0x20.
// - Slot B eight-bit delay to first pulse, reset 0x20.
// - Slot A code sets signs of samples one and two of each group of four.
// - Slot B code in bits 6:5 sets signs of samples one and two.
// - Slot A code sets signs of samples three and four; 00 add, 11 subtract.
// - Slot B code in bits 11:10 sets signs of samples three and four.
// - Control bit 7 lets the integrator act as buffer in TIA-to-ADC mode.
// - Float mode runs only when the slot's float enable equals 3.
// - Fire mask bit zero fires that pulse, one suppresses; lowest bit first pulse.

// ==========================================================================
// Register offsets
`define ADDR_BG_STATUS   8'h04
`define ADDR_A_LIMIT     8'h16
`define ADDR_B_LIMIT     8'h1C
`define ADDR_A_TIMING    8'h3E
`define ADDR_B_TIMING    8'h3F
`define ADDR_SIGN_CTL    8'h58

// ==========================================================================
// Field positions
`define SEL_MSB          15
`define SEL_LSB          14
`define LIMIT_MSB        13
`define WIDTH_MSB        12
`define WIDTH_LSB        8
`define DELAY_MSB        7
`define A12_MSB          2
`define A12_LSB          1
`define B12_MSB          6
`define B12_LSB          5
`define A34_MSB          9
`define A34_LSB          8
`define B34_MSB          11
`define B34_LSB          10
`define INTBUF_BIT       7

// ==========================================================================
// Reset values and codes
`define LIMIT_RST        16'h0000
`define TIMING_RST       16'h0320
`define SIGN_RST         16'h0000
`define FLOAT_ON         2'h3
`define TARGET_1         5'h01
`define TARGET_4         5'h04
`define TARGET_16        5'h10

// ==========================================================================
// Timing
`define CLK_PERIOD_NS    50
`define NS_PER_US        1000
`endif

// File: inc/float_pkg.sv
package float_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DELAY,
    SEQ_PULSE,
    SEQ_GAP
  } seq_state_t;

endpackage : float_pkg

// File: rtl/background_counter.sv
`timescale 1ns/1ns
`include "float_regs.svh"
module background_counter
  import float_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       hit,
  input  wire logic       clear,
  input  wire logic [1:0] count_select,
  output logic            flag
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic [4:0] target;

  always_comb
  begin
    case (count_select)
      2'h1:    target = `TARGET_1;
      2'h2:    target = `TARGET_4;
      default: target = `TARGET_16;
    endcase
    cnt_nxt = clear ? 5'h00 : cnt_r;
    // Saturate so a long run never wraps back below the target
    if (hit && cnt_nxt != `TARGET_16)
      cnt_nxt = cnt_nxt + 5'h01;
    // A hit in the clearing cycle still lands
    flag_nxt = (clear ? 1'b0 : flag_r)
             | (hit && count_select != 2'h0 && cnt_nxt >= target);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cnt_r  <= 5'h00;
      flag_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule : background_counter

// File: rtl/float_slot_seq.sv
`timescale 1ns/1ns
`include "float_regs.svh"
module float_slot_seq
  import float_pkg::*;
#(
  parameter int PULSES = 4,
  parameter int GAP_US = 1
)(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       enable,
  input  wire logic [1:0] emitter_choice,
  input  wire logic [4:0] pulse_width,
  input  wire logic [7:0] first_delay,
  input  wire logic [3:0] fire_mask,
  input  wire logic [3:0] pulse_signs,
  output logic      [2:0] led_drive,
  output logic            sample_subtract,
  output logic            active,
  output logic            done
);
  localparam int CYC_US = `NS_PER_US / `CLK_PERIOD_NS;

  if (PULSES % 4 != 0 || PULSES < 4 || PULSES > 252 || GAP_US < 1 || GAP_US > 255)
    $error("float_slot_seq: PULSES must be a multiple of 4 up to 252, GAP_US 1..255");

  seq_state_t state_r, state_nxt;
  logic [4:0] tick_r, tick_nxt;
  logic [7:0] units_r, units_nxt;
  logic [7:0] idx_r, idx_nxt;
  logic [2:0] led_r, led_nxt;
  logic       sub_r, sub_nxt;
  logic       done_r, done_nxt;
  logic       us_end;

  always_comb
  begin
    state_nxt = state_r;
    units_nxt = units_r;
    idx_nxt   = idx_r;
    sub_nxt   = sub_r;
    led_nxt   = 3'h0;
    done_nxt  = 1'b0;
    us_end    = tick_r == 5'(CYC_US - 1);
    tick_nxt  = (state_r == SEQ_IDLE || us_end) ? 5'h00 : tick_r + 5'h01;
    case (state_r)
      SEQ_IDLE:
        if (start && enable)
        begin
          state_nxt = SEQ_DELAY;
          units_nxt = first_delay;
          idx_nxt   = 8'h00;
          // No sign is in force before the first pulse, so a stale one is dropped
          sub_nxt   = 1'b0;
        end
      SEQ_DELAY:
        if (units_r == 8'h00)
        begin
          state_nxt = SEQ_PULSE;
          units_nxt = {3'h0, pulse_width};
          sub_nxt   = pulse_signs[idx_r[1:0]];
          tick_nxt  = 5'h00;
        end
        else if (us_end)
          units_nxt = units_r - 8'h01;
      SEQ_PULSE:
      begin
        if (units_r != 8'h00 && !fire_mask[idx_r[1:0]])
          case (emitter_choice)
            2'h1:    led_nxt = 3'h1;
            2'h2:    led_nxt = 3'h2;
            2'h3:    led_nxt = 3'h4;
            default: led_nxt = 3'h0;
          endcase
        if (units_r == 8'h00)
        begin
          state_nxt = SEQ_GAP;
          units_nxt = 8'(GAP_US);
          tick_nxt  = 5'h00;
        end
        else if (us_end)
          units_nxt = units_r - 8'h01;
      end
      SEQ_GAP:
        if (units_r == 8'h00)
        begin
          tick_nxt = 5'h00;
          if (idx_r == 8'(PULSES - 1))
          begin
            state_nxt = SEQ_IDLE;
            done_nxt  = 1'b1;
          end
          else
          begin
            state_nxt = SEQ_PULSE;
            idx_nxt   = idx_r + 8'h01;
            units_nxt = {3'h0, pulse_width};
            sub_nxt   = pulse_signs[idx_nxt[1:0]];
          end
        end
        else if (us_end)
          units_nxt = units_r - 8'h01;
      default:
        state_nxt = SEQ_IDLE;
    endcase
    // Dropping the enable mid-slot aborts without a done pulse
    if (!enable)
    begin
      state_nxt = SEQ_IDLE;
      led_nxt   = 3'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_r <= SEQ_IDLE;
      tick_r  <= 5'h00;
      units_r <= 8'h00;
      idx_r   <= 8'h00;
      led_r   <= 3'h0;
      sub_r   <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tick_r  <= tick_nxt;
      units_r <= units_nxt;
      idx_r   <= idx_nxt;
      led_r   <= led_nxt;
      sub_r   <= sub_nxt;
      done_r  <= done_nxt;
    end
  end

  assign led_drive       = led_r;
  assign sample_subtract = sub_r;
  assign active          = state_r != SEQ_IDLE;
  assign done            = done_r;

endmodule : float_slot_seq

// File: rtl/float_mode_background_monitor.sv
`timescale 1ns/1ns
`include "float_regs.svh"
module float_mode_background_monitor
  import float_pkg::*;
#(
  parameter int PULSES = 4,
  parameter int GAP_US = 1,
  parameter int ACC_W  = 20
)(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [15:0]        reg_wdata,
  output logic      [15:0]        reg_rdata,
  // Neighbouring controls
  input  wire logic [1:0]         slot_a_float_enable,
  input  wire logic [1:0]         slot_b_float_enable,
  input  wire logic [3:0]         slot_a_pulse_fire_mask,
  input  wire logic [3:0]         slot_b_pulse_fire_mask,
  input  wire logic               tia_adc_mode,
  // Slot timing
  input  wire logic               slot_a_start,
  input  wire logic               slot_b_start,
  // Converter results
  input  wire logic               adc_valid,
  input  wire logic               adc_slot_b,
  input  wire logic [1:0]         adc_chan,
  input  wire logic [13:0]        adc_result,
  // Emitters and front end
  output logic      [2:0]         slot_a_led_drive,
  output logic      [2:0]         slot_b_led_drive,
  output logic                    slot_a_float_active,
  output logic                    slot_b_float_active,
  output logic                    integrator_buffer_enable,
  // Signed sums, channel 1 in the low slice
  output logic      [4*ACC_W-1:0] slot_a_float_sums,
  output logic      [4*ACC_W-1:0] slot_b_float_sums,
  output logic                    slot_a_sums_done,
  output logic                    slot_b_sums_done
);
  if (ACC_W < 15 || ACC_W > 32)
    $error("float_mode_background_monitor: ACC_W must lie in 15..32");

  // ==========================================================================
  // Register file

  logic [15:0] limit_a_r, limit_a_nxt;
  logic [15:0] limit_b_r, limit_b_nxt;
  logic [15:0] timing_a_r, timing_a_nxt;
  logic [15:0] timing_b_r, timing_b_nxt;
  logic [15:0] sign_ctl_r, sign_ctl_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        intbuf_r, intbuf_nxt;
  logic [7:0]  flags;
  logic        status_clear;

  always_comb
  begin
    limit_a_nxt  = limit_a_r;
    limit_b_nxt  = limit_b_r;
    timing_a_nxt = timing_a_r;
    timing_b_nxt = timing_b_r;
    sign_ctl_nxt = sign_ctl_r;
    if (reg_wr)
      case (reg_addr)
        `ADDR_A_LIMIT:  limit_a_nxt  = reg_wdata;
        `ADDR_B_LIMIT:  limit_b_nxt  = reg_wdata;
        `ADDR_A_TIMING: timing_a_nxt = reg_wdata;
        `ADDR_B_TIMING: timing_b_nxt = reg_wdata;
        `ADDR_SIGN_CTL: sign_ctl_nxt = reg_wdata;
        default:        limit_a_nxt  = limit_a_r;
      endcase
  end

  // Read data is registered; the status register is latched and cleared in
  // the same cycle, so a flag set on that edge is not lost but held over.
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd)
      case (reg_addr)
        `ADDR_BG_STATUS: rdata_nxt = {8'h00, flags};
        `ADDR_A_LIMIT:   rdata_nxt = limit_a_r;
        `ADDR_B_LIMIT:   rdata_nxt = limit_b_r;
        `ADDR_A_TIMING:  rdata_nxt = timing_a_r;
        `ADDR_B_TIMING:  rdata_nxt = timing_b_r;
        `ADDR_SIGN_CTL:  rdata_nxt = sign_ctl_r;
        default:         rdata_nxt = 16'h0000;
      endcase
  end

  assign status_clear = reg_rd && reg_addr == `ADDR_BG_STATUS;

  // The buffer option only takes hold while the front end runs TIA-to-ADC
  assign intbuf_nxt = sign_ctl_r[`INTBUF_BIT] && tia_adc_mode;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      limit_a_r  <= `LIMIT_RST;
      limit_b_r  <= `LIMIT_RST;
      timing_a_r <= `TIMING_RST;
      timing_b_r <= `TIMING_RST;
      sign_ctl_r <= `SIGN_RST;
      rdata_r    <= 16'h0000;
      intbuf_r   <= 1'b0;
    end
    else
    begin
      limit_a_r  <= limit_a_nxt;
      limit_b_r  <= limit_b_nxt;
      timing_a_r <= timing_a_nxt;
      timing_b_r <= timing_b_nxt;
      sign_ctl_r <= sign_ctl_nxt;
      rdata_r    <= rdata_nxt;
      intbuf_r   <= intbuf_nxt;
    end
  end

  assign reg_rdata                = rdata_r;
  assign integrator_buffer_enable = intbuf_r;

  // ==========================================================================
  // Pulse sign decode

  // Per pulse position, 1 means the sample is subtracted. In each pair code
  // the upper bit belongs to the earlier sample.
  logic [3:0] signs_a;
  logic [3:0] signs_b;
  logic       float_on_a;
  logic       float_on_b;

  assign signs_a = {sign_ctl_r[`A34_LSB], sign_ctl_r[`A34_MSB],
                    sign_ctl_r[`A12_LSB], sign_ctl_r[`A12_MSB]};
  assign signs_b = {sign_ctl_r[`B34_LSB], sign_ctl_r[`B34_MSB],
                    sign_ctl_r[`B12_LSB], sign_ctl_r[`B12_MSB]};

  assign float_on_a = slot_a_float_enable == `FLOAT_ON;
  assign float_on_b = slot_b_float_enable == `FLOAT_ON;

  // ==========================================================================
  // Slot sequencers

  logic sub_a;
  logic sub_b;
  logic done_a;
  logic done_b;

  float_slot_seq #(
    .PULSES (PULSES),
    .GAP_US (GAP_US)
  ) u_seq_a (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .start           (slot_a_start),
    .enable          (float_on_a),
    .emitter_choice  (timing_a_r[`SEL_MSB:`SEL_LSB]),
    .pulse_width     (timing_a_r[`WIDTH_MSB:`WIDTH_LSB]),
    .first_delay     (timing_a_r[`DELAY_MSB:0]),
    .fire_mask       (slot_a_pulse_fire_mask),
    .pulse_signs     (signs_a),
    .led_drive       (slot_a_led_drive),
    .sample_subtract (sub_a),
    .active          (slot_a_float_active),
    .done            (done_a)
  );

  float_slot_seq #(
    .PULSES (PULSES),
    .GAP_US (GAP_US)
  ) u_seq_b (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .start           (slot_b_start),
    .enable          (float_on_b),
    .emitter_choice  (timing_b_r[`SEL_MSB:`SEL_LSB]),
    .pulse_width     (timing_b_r[`WIDTH_MSB:`WIDTH_LSB]),
    .first_delay     (timing_b_r[`DELAY_MSB:0]),
    .fire_mask       (slot_b_pulse_fire_mask),
    .pulse_signs     (signs_b),
    .led_drive       (slot_b_led_drive),
    .sample_subtract (sub_b),
    .active          (slot_b_float_active),
    .done            (done_b)
  );

  assign slot_a_sums_done = done_a;
  assign slot_b_sums_done = done_b;

  // ==========================================================================
  // Background comparison and per-channel flags

  // Entries 0..3 are slot A channels 1..4, entries 4..7 slot B.
  logic [7:0] hit;

  for (genvar g = 0; g < 8; g++)
  begin : g_chan
    localparam logic       IS_B = (g >= 4);
    localparam logic [1:0] CH   = 2'(g % 4);
    logic take;
    logic over;

    assign take = adc_valid && adc_slot_b == IS_B && adc_chan == CH
               && (IS_B ? (float_on_b && slot_b_float_active && sub_b)
                        : (float_on_a && slot_a_float_active && sub_a));
    assign over = IS_B ? (adc_result > limit_b_r[`LIMIT_MSB:0])
                       : (adc_result > limit_a_r[`LIMIT_MSB:0]);
    assign hit[g] = take && over;

    background_counter u_cnt (
      .core_clk     (core_clk),
      .rstn         (rstn),
      .hit          (hit[g]),
      .clear        (status_clear),
      .count_select (IS_B ? limit_b_r[`SEL_MSB:`SEL_LSB] : limit_a_r[`SEL_MSB:`SEL_LSB]),
      .flag         (flags[g])
    );
  end

  // ==========================================================================
  // Signed sample sums

  // One running sum per slot and channel; cleared when the slot starts so the
  // previous result stays readable until a new slot begins.
  logic signed [ACC_W-1:0] acc_r   [8];
  logic signed [ACC_W-1:0] acc_nxt [8];

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      acc_nxt[i] = acc_r[i];
      if (i < 4 ? (slot_a_start && float_on_a && !slot_a_float_active)
                : (slot_b_start && float_on_b && !slot_b_float_active))
        acc_nxt[i] = '0;
      else if (adc_valid && adc_slot_b == (i >= 4) && adc_chan == 2'(i % 4)
               && (i < 4 ? slot_a_float_active : slot_b_float_active))
      begin
        if (i < 4 ? sub_a : sub_b)
          acc_nxt[i] = acc_r[i] - ACC_W'(adc_result);
        else
          acc_nxt[i] = acc_r[i] + ACC_W'(adc_result);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!rstn)
        acc_r[i] <= '0;
      else
        acc_r[i] <= acc_nxt[i];
    end
  end

  for (genvar c = 0; c < 4; c++)
  begin : g_sum
    assign slot_a_float_sums[c*ACC_W +: ACC_W] = acc_r[c];
    assign slot_b_float_sums[c*ACC_W +: ACC_W] = acc_r[c+4];
  end

endmodule : float_mode_background_monitor

// File: bench/float_mode_background_monitor_checker.sv
`timescale 1ns/1ns
`include "float_regs.svh"
module float_mode_background_monitor_checker
  import float_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        adc_valid,
  input wire logic [1:0]  slot_a_float_enable,
  input wire logic [1:0]  slot_b_float_enable,
  input wire logic        slot_a_start,
  input wire logic        tia_adc_mode,
  input wire logic [2:0]  slot_a_led_drive,
  input wire logic [2:0]  slot_b_led_drive,
  input wire logic        slot_a_float_active,
  input wire logic        slot_b_float_active,
  input wire logic        integrator_buffer_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Status register
  AST_STATUS_HIGH_ZERO: assert property (reg_rd && reg_addr == `ADDR_BG_STATUS |=> reg_rdata[15:8] == 8'h00)
    else $error("status upper byte not zero");
  // Back-to-back reads with no sample in between must see the clear land
  AST_STATUS_CLEARED: assert property ((reg_rd && reg_addr == `ADDR_BG_STATUS && !adc_valid) ##1
    (reg_rd && reg_addr == `ADDR_BG_STATUS && !adc_valid) |=> reg_rdata == 16'h0000)
    else $error("status not cleared by read");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // ==========================================================================
  // Emitters and sequencer
  AST_LED_A_ONEHOT: assert property ($onehot0(slot_a_led_drive))
    else $error("slot A drives more than one emitter");
  AST_LED_B_ONEHOT: assert property ($onehot0(slot_b_led_drive))
    else $error("slot B drives more than one emitter");
  AST_LED_A_IDLE: assert property (!slot_a_float_active && !$past(slot_a_float_active)
    |-> slot_a_led_drive == 3'h0)
    else $error("slot A emitter on while idle");
  AST_FLOAT_OFF_B: assert property (slot_b_float_enable != `FLOAT_ON |-> ##[1:2] !slot_b_float_active)
    else $error("slot B active without float enable");
  AST_START_A: assert property (slot_a_start && slot_a_float_enable == `FLOAT_ON && !slot_a_float_active
    |=> slot_a_float_active)
    else $error("slot A start not taken");
  AST_INTBUF_GATE: assert property (!tia_adc_mode |=> !integrator_buffer_enable)
    else $error("integrator buffer outside TIA-to-ADC mode");
endmodule : float_mode_background_monitor_checker

bind float_mode_background_monitor float_mode_background_monitor_checker float_mode_background_monitor_checker_i (
  .core_clk, .rstn, .reg_addr, .reg_rd, .reg_rdata, .adc_valid, .slot_a_float_enable, .slot_b_float_enable,
  .slot_a_start, .tia_adc_mode, .slot_a_led_drive, .slot_b_led_drive, .slot_a_float_active, .slot_b_float_active,
  .integrator_buffer_enable);

// File: bench/tb_float_mode_background_monitor.sv
`timescale 1ns/1ns
`include "float_regs.svh"
module tb_float_mode_background_monitor import float_pkg::*;;
  localparam int ACC_W = 20;
  localparam logic [13:0] LIM = 14'h1000;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tia_adc_mode = 1'b0, slot_a_start = 1'b0, slot_b_start = 1'b0;
  logic adc_valid = 1'b0, adc_slot_b = 1'b0;
  logic [1:0] slot_a_float_enable = 2'h0, slot_b_float_enable = 2'h0, adc_chan = 2'h0;
  logic [3:0] slot_a_pulse_fire_mask = 4'h0, slot_b_pulse_fire_mask = 4'h0;
  logic [13:0] adc_result = 14'h0000;
  logic [15:0] reg_rdata;
  logic [2:0] slot_a_led_drive, slot_b_led_drive;
  logic slot_a_float_active, slot_b_float_active, integrator_buffer_enable, slot_a_sums_done, slot_b_sums_done;
  logic [4*ACC_W-1:0] slot_a_float_sums, slot_b_float_sums;
  logic seq_b = 1'b0;
  int n_fail = 0;
  int n_checks = 0;
  int led_cnt = 0;
  int cyc = 0;
  logic [7:0] adr [7] = '{8'h04, 8'h16, 8'h1C, 8'h3E, 8'h3F, 8'h58, 8'h20};
  logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0320, 16'h0320, 16'h0000, 16'h0000};

  float_mode_background_monitor #(.ACC_W(ACC_W)) float_mode_background_monitor_i (
    .core_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .slot_a_float_enable,
    .slot_b_float_enable, .slot_a_pulse_fire_mask, .slot_b_pulse_fire_mask, .tia_adc_mode, .slot_a_start,
    .slot_b_start, .adc_valid, .adc_slot_b, .adc_chan, .adc_result, .slot_a_led_drive, .slot_b_led_drive,
    .slot_a_float_active, .slot_b_float_active, .integrator_buffer_enable, .slot_a_float_sums,
    .slot_b_float_sums, .slot_a_sums_done, .slot_b_sums_done);

  // ==========================================================================
  // Clock, timeout and emitter-on counter
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (slot_a_start || slot_b_start)
      led_cnt <= 0;
    else if ((seq_b ? slot_b_led_drive : slot_a_led_drive) != 3'h0)
      led_cnt <= led_cnt + 1;
  end

  // Whole run needs well under 10k cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      $display("MISMATCH t=%0t timeout", $time);
      n_fail++;
      test_done();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd_chk

  // Two back-to-back status reads: flags, then cleared
  task automatic st_chk(input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= `ADDR_BG_STATUS;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    #1 chk(reg_rdata, {8'h00, e});
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 16'h0000);
  endtask : st_chk

  // One float sequence: 1 us delay, 1 us pulses; h samples above limit and one at it,
  // sent w cycles later (42 cycles per pulse and gap)
  task automatic run_seq(input logic b, input logic [1:0] ch, input int h, input logic [1:0] cho,
                         input logic sub, input logic [3:0] m, input int w = 0);
    int k;
    int tot;
    logic [4*ACC_W-1:0] v;
    tot = h * (int'(LIM) + 1) + int'(LIM);
    if (sub)
      tot = -tot;
    seq_b = b;
    wr(b ? `ADDR_B_TIMING : `ADDR_A_TIMING, {cho, 14'h0101});
    @(posedge core_clk);
    slot_a_pulse_fire_mask <= m;
    slot_b_pulse_fire_mask <= m;
    slot_a_start <= !b;
    slot_b_start <= b;
    @(posedge core_clk);
    slot_a_start <= 1'b0;
    slot_b_start <= 1'b0;
    repeat (24) @(posedge core_clk);
    #1 chk(b ? slot_b_led_drive : slot_a_led_drive,
           (cho == 2'h0 || m[0]) ? 3'h0 : 3'h1 << (cho - 2'h1));
    repeat (w) @(posedge core_clk);
    for (k = 0; k <= h; k++)
    begin
      @(posedge core_clk);
      adc_valid <= 1'b1;
      adc_slot_b <= b;
      adc_chan <= ch;
      adc_result <= (k < h) ? LIM + 14'h1 : LIM;
    end
    @(posedge core_clk);
    adc_valid <= 1'b0;
    k = 0;
    while (k < 600 && (b ? slot_b_sums_done : slot_a_sums_done) !== 1'b1)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk(k < 600, 1'b1);
    chk(led_cnt, cho == 2'h0 ? 0 : 20 * (4 - $countones(m)));
    v = b ? slot_b_float_sums : slot_a_float_sums;
    chk(v[ch*ACC_W +: ACC_W], tot[ACC_W-1:0]);
  endtask : run_seq

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Main sequence
  initial
  begin
    int t;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd_chk(adr[i], rv[i]);
    for (int i = 0; i < 7; i++)
      wr(adr[i], 16'hC3A5);
    for (int i = 0; i < 7; i++)
      rd_chk(adr[i], (i == 0 || i == 6) ? 16'h0000 : 16'hC3A5);
    wr(`ADDR_SIGN_CTL, 16'h0F66);
    slot_a_float_enable <= `FLOAT_ON;
    slot_b_float_enable <= `FLOAT_ON;
    // Run target-1 twice so a counter that survives the read would trip
    for (int b = 0; b < 2; b++)
      for (int s = 0; s < 4; s++)
      begin
        t = (s == 1) ? 1 : (s == 2) ? 4 : 16;
        wr(b ? `ADDR_B_LIMIT : `ADDR_A_LIMIT, {s[1:0], LIM});
        for (int r = 0; r < 3; r++)
        begin
          run_seq(b[0], s[1:0], (r == 2 || s == 0) ? t : t - 1, s[1:0], 1'b1, 4'h0);
          st_chk((r == 2 && s != 0) ? 8'h01 << (b * 4 + s) : 8'h00);
        end
      end
    wr(`ADDR_A_LIMIT, {2'h1, LIM});
    // Codes 01 and 10 on sample one, then code 01 of the second pair on samples three and four
    for (int c = 1; c < 5; c++)
    begin
      wr(`ADDR_SIGN_CTL, (c < 3) ? 16'(c << 1) : 16'h0100);
      run_seq(1'b0, 2'h0, 1, 2'h1, !c[0], 4'h0, (c < 3) ? 0 : 42 * (c - 1));
      st_chk(c[0] ? 8'h00 : 8'h01);
    end
    // Slot B: sample one added, then sample four subtracted by the second pair code
    for (int c = 0; c < 2; c++)
    begin
      wr(`ADDR_SIGN_CTL, c[0] ? 16'h0400 : 16'h0000);
      run_seq(1'b1, 2'h2, 16, 2'h3, c[0], 4'h5, c * 126);
      st_chk(c[0] ? 8'h40 : 8'h00);
    end
    @(posedge core_clk);
    slot_a_float_enable <= 2'h2;
    slot_a_start <= 1'b1;
    @(posedge core_clk);
    slot_a_start <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(slot_a_float_active, 1'b0);
    wr(`ADDR_SIGN_CTL, 16'h0080);
    tia_adc_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk(integrator_buffer_enable, 1'b1);
    @(posedge core_clk);
    tia_adc_mode <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(integrator_buffer_enable, 1'b0);
    test_done();
  end
endmodule : tb_float_mode_background_monitor
